//--- sysopt_defines.svh
/*
 system options, part number and periodic wakeup register block:
 register offsets, field positions, reset values and period bases.
 assumes inclusion by bare name from every file that decodes registers.
*/
// Notes on behaviour
// - watchdog clock select: internal 1-kHz or bus
// - watchdog clock select writable once per reset
// - pin-select bit moves two-wire bus pins
// - comparator routing bit feeds capture channel 0
// - high id upper nibble reserved, writes ignored
// - fixed read-only 12-bit part number
// - wakeup flag set on each period timeout
// - acknowledge write-1 clears flag, reads zero
// - wakeup clock select: internal or external
// - wakeup interrupt enable gates the request
// - period select zero stops the timer
// - internal periods 8 ms to 1.024 s
// - external periods 256 to 32768 clocks
// - first timeout may come one tick early
`ifndef SYSOPT_DEFINES_SVH
`define SYSOPT_DEFINES_SVH

// byte addresses on the register bus
`define OFF_SYSTEM_OPTIONS_SECOND 32'h0000_0000
`define OFF_PART_NUMBER_HIGH      32'h0000_0004
`define OFF_PART_NUMBER_LOW       32'h0000_0008
`define OFF_WAKEUP_STATUS_CONTROL 32'h0000_000C
`define OFF_IRQ_STATUS            32'h0000_0010
`define OFF_IRQ_MASK              32'h0000_0014

// options register fields
`define BIT_WATCHDOG_CLOCK_SELECT 7
`define BIT_TWOWIRE_PIN_SELECT    1
`define BIT_COMPARATOR_TO_CAPTURE 0

// wakeup status and control fields
`define BIT_WAKEUP_FLAG           7
`define BIT_WAKEUP_ACKNOWLEDGE    6
`define BIT_WAKEUP_CLOCK_SELECT   5
`define BIT_WAKEUP_INT_ENABLE     4

// reset values
`define RST_WATCHDOG_CLOCK_SELECT 1'h0
`define RST_TWOWIRE_PIN_SELECT    1'h0
`define RST_COMPARATOR_TO_CAPTURE 1'h0
`define RST_WAKEUP_PERIOD_SELECT  3'h0
`define RST_IRQ_MASK              1'h0

// period bases in ticks: code 1 gives base, code n>1 gives base << n
`define WAKEUP_INT_BASE           16'h0008
`define WAKEUP_EXT_BASE           16'h0100

// bus answers
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

//--- sysopt_pkg.sv
/*
 types shared by the system options block and its wakeup ticker.
 assumes nothing of its surroundings.
*/
package sysopt_pkg;

   // write channel sequence, gray along idle -> commit -> respond
   typedef enum logic [1:0]
   {
      WR_IDLE   = 2'b00,
      WR_COMMIT = 2'b01,
      WR_RESP   = 2'b11
   } wr_state_e;

   // wakeup ticker state
   typedef struct packed
   {
      logic [15:0] cnt;      // ticks counted in this period
      logic [3:0]  cfg;      // clock select and period code last seen
      logic        timeout;  // one-cycle timeout pulse
   } ticker_s;

   // register block state
   typedef struct packed
   {
      wr_state_e   wst;       // write sequence
      logic        aw_have;   // write address captured
      logic        w_have;    // write data captured
      logic        awready;   // bus handshakes
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [31:0] awaddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        wdog_cs;   // watchdog clock select
      logic        wdog_lock; // options written once since reset
      logic        pin_sel;   // two-wire pin placement
      logic        cmp_route; // comparator to capture routing
      logic        flag;      // wakeup flag
      logic        wk_clks;   // wakeup clock select
      logic        wk_ie;     // wakeup interrupt enable
      logic [2:0]  wk_sel;    // wakeup period select
      logic        irq_stat;  // sticky timeout event
      logic        irq_mask;
      logic [2:0]  sy1;       // pin synchronisers
      logic [2:0]  sy2;
      logic [2:0]  sy3;       // edge history
      logic        wreq;      // registered outputs
      logic        irq;
      logic        wdog_tick;
      logic        cap_ch0;
   } regs_s;

endpackage

//--- wakeup_ticker.sv
/*
 periodic wakeup ticker: counts ticks of the selected source and pulses
 a timeout at the end of each selected period.
 assumes one-cycle tick strobes already synchronised to aclk.
*/
module wakeup_ticker
   import sysopt_pkg::*;
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // tick strobes
   input  wire logic       tick_int,
   input  wire logic       tick_ext,
   // configuration
   input  wire logic       clk_sel,
   input  wire logic [2:0] period_sel,
   // result
   output logic            timeout
);
`include "sysopt_defines.svh"

   ticker_s     q;        // registered state
   ticker_s     d;        // next state
   logic        tick;     // selected tick
   logic [15:0] period;   // ticks per period

   // period lookup for both sources
   always_comb
   begin
      logic [15:0] base;
      base = clk_sel ? `WAKEUP_EXT_BASE : `WAKEUP_INT_BASE;
      if (period_sel == 3'h1)
      begin
         period = base;
      end
      else
      begin
         period = base << period_sel;
      end
   end

   assign tick = clk_sel ? tick_ext : tick_int;

   // count and pulse
   always_comb
   begin
      d = q;
      d.timeout = 1'b0;
      d.cfg = {clk_sel, period_sel};
      if (!aresetn)
      begin
         d = '0;
      end
      else if (period_sel == 3'h0)
      begin
         d.cnt = '0;
      end
      else if (q.cfg != {clk_sel, period_sel})
      begin
         // restart; a tick part-way done makes the first period short
         d.cnt = '0;
      end
      else if (tick)
      begin
         if (q.cnt == period - 16'h0001)
         begin
            d.cnt = '0;
            d.timeout = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt + 16'h0001;
         end
      end
   end

   // state register
   always_ff @(posedge aclk)
   begin
      q <= d;
   end

   assign timeout = q.timeout;

endmodule

//--- sysopt_top.sv
/*
 system options, part number and periodic wakeup registers behind an
 axi4-lite slave, with a sticky wakeup event and one interrupt output.
 assumes oscillator, crystal and comparator inputs are asynchronous pins
 and that the bus master keeps at most one read and one write open.
*/
// Our own choices: the address map and register access over AXI4-Lite.
module sysopt_top
   import sysopt_pkg::*;
#(
   parameter logic [11:0] PART_NUMBER = 12'h0_5A3 // value arbitrary
)
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // asynchronous sources
   input  wire logic        osc_1khz_in,
   input  wire logic        ext_crystal_in,
   input  wire logic        analog_comparator_out,
   // option outputs
   output logic             watchdog_clock_select,
   output logic             watchdog_tick,
   output logic             twowire_pin_select,
   output logic             comparator_to_capture,
   output logic             capture_ch0_from_comparator,
   // wakeup and interrupt
   output logic             wakeup_request,
   output logic             irq
);
`include "sysopt_defines.svh"

   regs_s q;            // registered state
   regs_s d;            // next state
   logic  tick_int;     // 1-kHz rising edge
   logic  tick_ext;     // crystal rising edge
   logic  wk_timeout;   // period reached
   logic  flag_clr;     // acknowledge written
   logic  stat_clr;     // event status cleared

   // rising edges seen on the second and third stages only
   assign tick_int = q.sy2[0] & ~q.sy3[0];
   assign tick_ext = q.sy2[1] & ~q.sy3[1];

   // periodic wakeup counter
   wakeup_ticker u_ticker
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick_int   (tick_int),
      .tick_ext   (tick_ext),
      .clk_sel    (q.wk_clks),
      .period_sel (q.wk_sel),
      .timeout    (wk_timeout)
   );

   // next-state logic: bus, registers, flags, outputs
   always_comb
   begin
      d = q;
      flag_clr = 1'b0;
      stat_clr = 1'b0;
      // pins pass two flops before anything reads them
      d.sy1 = {analog_comparator_out, ext_crystal_in, osc_1khz_in};
      d.sy2 = q.sy1;
      d.sy3 = q.sy2;

      // write channel
      case (q.wst)
         WR_IDLE:
         begin
            // address and data in either order
            if (s_axi_awvalid && q.awready)
            begin
               d.awaddr = s_axi_awaddr;
               d.aw_have = 1'b1;
               d.awready = 1'b0;
            end
            if (s_axi_wvalid && q.wready)
            begin
               d.wdata = s_axi_wdata[7:0];
               d.wstrb0 = s_axi_wstrb[0];
               d.w_have = 1'b1;
               d.wready = 1'b0;
            end
            if (d.aw_have && d.w_have)
            begin
               d.wst = WR_COMMIT;
            end
         end
         WR_COMMIT:
         begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            d.wst = WR_RESP;
            if (q.awaddr == `OFF_SYSTEM_OPTIONS_SECOND)
            begin
               if (q.wstrb0)
               begin
                  if (!q.wdog_lock)
                  begin
                     d.wdog_cs = q.wdata[`BIT_WATCHDOG_CLOCK_SELECT];
                     d.wdog_lock = 1'b1;
                  end
                  d.pin_sel = q.wdata[`BIT_TWOWIRE_PIN_SELECT];
                  d.cmp_route = q.wdata[`BIT_COMPARATOR_TO_CAPTURE];
               end
            end
            else if (q.awaddr == `OFF_PART_NUMBER_HIGH)
            begin
               // read-only, whole byte ignored
               d.bresp = `RESP_OKAY;
            end
            else if (q.awaddr == `OFF_PART_NUMBER_LOW)
            begin
               // read-only
               d.bresp = `RESP_OKAY;
            end
            else if (q.awaddr == `OFF_WAKEUP_STATUS_CONTROL)
            begin
               if (q.wstrb0)
               begin
                  flag_clr = q.wdata[`BIT_WAKEUP_ACKNOWLEDGE];
                  d.wk_clks = q.wdata[`BIT_WAKEUP_CLOCK_SELECT];
                  d.wk_ie = q.wdata[`BIT_WAKEUP_INT_ENABLE];
                  d.wk_sel = q.wdata[2:0];
               end
            end
            else if (q.awaddr == `OFF_IRQ_STATUS)
            begin
               stat_clr = q.wstrb0 & q.wdata[0];
            end
            else if (q.awaddr == `OFF_IRQ_MASK)
            begin
               if (q.wstrb0)
               begin
                  d.irq_mask = q.wdata[0];
               end
            end
            else
            begin
               // unmapped address
               d.bresp = `RESP_SLVERR;
            end
         end
         WR_RESP:
         begin
            // reopen both channels once the answer is taken
            if (s_axi_bready)
            begin
               d.bvalid = 1'b0;
               d.awready = 1'b1;
               d.wready = 1'b1;
               d.wst = WR_IDLE;
            end
         end
         default:
         begin
            d.wst = WR_IDLE;
         end
      endcase

      // read channel, one cycle to data
      if (s_axi_arvalid && q.arready)
      begin
         d.arready = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = `RESP_OKAY;
         d.rdata = 32'h0000_0000;
         if (s_axi_araddr == `OFF_SYSTEM_OPTIONS_SECOND)
         begin
            d.rdata[7:0] = {q.wdog_cs, 5'h00, q.pin_sel, q.cmp_route};
         end
         else if (s_axi_araddr == `OFF_PART_NUMBER_HIGH)
         begin
            // reserved nibble reads zero
            d.rdata[7:0] = {4'h0, PART_NUMBER[11:8]};
         end
         else if (s_axi_araddr == `OFF_PART_NUMBER_LOW)
         begin
            d.rdata[7:0] = PART_NUMBER[7:0];
         end
         else if (s_axi_araddr == `OFF_WAKEUP_STATUS_CONTROL)
         begin
            // acknowledge bit always reads zero
            d.rdata[7:0] = {q.flag, 1'b0, q.wk_clks, q.wk_ie,
                            1'b0, q.wk_sel};
         end
         else if (s_axi_araddr == `OFF_IRQ_STATUS)
         begin
            d.rdata[0] = q.irq_stat;
         end
         else if (s_axi_araddr == `OFF_IRQ_MASK)
         begin
            d.rdata[0] = q.irq_mask;
         end
         else
         begin
            d.rresp = `RESP_SLVERR;
         end
      end
      else if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
         d.arready = 1'b1;
      end

      // flags: a timeout in the clearing cycle wins
      if (flag_clr)
      begin
         d.flag = 1'b0;
      end
      if (stat_clr)
      begin
         d.irq_stat = 1'b0;
      end
      if (wk_timeout)
      begin
         d.flag = 1'b1;
         d.irq_stat = 1'b1;
      end

      // registered outputs
      d.wreq = d.flag & d.wk_ie;
      d.irq = d.irq_stat & d.irq_mask;
      d.wdog_tick = q.wdog_cs ? tick_int : 1'b1;
      d.cap_ch0 = q.cmp_route & q.sy2[2];

      // synchronous reset
      if (!aresetn)
      begin
         d = '0;
         d.wst = WR_IDLE;
         d.awready = 1'b1;
         d.wready = 1'b1;
         d.arready = 1'b1;
         d.wdog_cs = `RST_WATCHDOG_CLOCK_SELECT;
         d.pin_sel = `RST_TWOWIRE_PIN_SELECT;
         d.cmp_route = `RST_COMPARATOR_TO_CAPTURE;
         d.wk_sel = `RST_WAKEUP_PERIOD_SELECT;
         d.irq_mask = `RST_IRQ_MASK;
      end
   end

   // state register
   always_ff @(posedge aclk)
   begin
      q <= d;
   end

   // ports straight from flops
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign watchdog_clock_select = q.wdog_cs;
   assign watchdog_tick = q.wdog_tick;
   assign twowire_pin_select = q.pin_sel;
   assign comparator_to_capture = q.cmp_route;
   assign capture_ch0_from_comparator = q.cap_ch0;
   assign wakeup_request = q.wreq;
   assign irq = q.irq;

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // once locked the watchdog select never moves
   AST_WDOG_LOCK: assert property (
      q.wdog_lock |=> $stable(q.wdog_cs))
      else $error("watchdog clock select changed after lock");

   // bus clock source gives a tick every cycle
   AST_WDOG_SRC: assert property (
      aresetn && !q.wdog_cs |=> watchdog_tick)
      else $error("bus clock watchdog tick missing");

   // timeout raises the flag next cycle
   AST_FLAG_SET: assert property (
      wk_timeout |=> q.flag)
      else $error("wakeup flag not set on timeout");

   // acknowledge clears the flag unless a timeout coincides
   AST_ACK_CLR: assert property (
      (q.wst == WR_COMMIT && q.awaddr == `OFF_WAKEUP_STATUS_CONTROL
       && q.wstrb0 && q.wdata[6] && !wk_timeout) |=> !q.flag)
      else $error("acknowledge did not clear wakeup flag");

   // acknowledge bit reads zero
   AST_ACK_RD: assert property (
      (s_axi_arvalid && s_axi_arready
       && s_axi_araddr == `OFF_WAKEUP_STATUS_CONTROL)
      |=> s_axi_rvalid && !s_axi_rdata[6])
      else $error("acknowledge bit read back as one");

   // high part number byte with reserved nibble
   AST_ID_RD: assert property (
      (s_axi_arvalid && s_axi_arready
       && s_axi_araddr == `OFF_PART_NUMBER_HIGH)
      |=> s_axi_rdata[7:0] == {4'h0, PART_NUMBER[11:8]})
      else $error("part number high byte wrong");

   // period code zero never times out
   AST_STOP: assert property (
      (q.wk_sel == 3'h0) [*2] |-> !wk_timeout)
      else $error("timeout while wakeup timer stopped");

   // request follows flag and enable together
   AST_REQ: assert property (
      wakeup_request == (q.flag && q.wk_ie))
      else $error("wakeup request disagrees with flag and enable");

   // write commit answers next cycle
   AST_BRESP: assert property (
      q.wst == WR_COMMIT |=> s_axi_bvalid ##0 q.wst == WR_RESP)
      else $error("write response late");

   // main scenarios
   COV_TIMEOUT: cover property (wk_timeout ##1 wakeup_request);
   COV_ACK: cover property (q.flag ##1 !q.flag);
   COV_EXT: cover property (q.wk_clks && wk_timeout);

endmodule

//--- sysopt_top_bench.sv
/*
 self-checking bench for the options, part number and wakeup registers.
 assumes sysopt_top and the register defines header on the include path.
*/
`include "sysopt_defines.svh"

// one comparison, counted; mismatch printed at once
`define CHECK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("unexpected at %0t: got %h expected %h", \
                  $time, (got), (exp)); \
      end \
   end

module sysopt_top_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [11:0] PN  = 12'h6B1; // value arbitrary
   localparam logic [1:0]  OK  = `RESP_OKAY;
   localparam logic [1:0]  ERR = `RESP_SLVERR;
   localparam logic [31:0] OPT = `OFF_SYSTEM_OPTIONS_SECOND;
   localparam logic [31:0] WK  = `OFF_WAKEUP_STATUS_CONTROL;
   localparam logic [31:0] STA = `OFF_IRQ_STATUS;
   localparam logic [31:0] MSK = `OFF_IRQ_MASK;

   // clock, reset and bus
   logic        aclk;
   logic        aresetn;
   logic [31:0] s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [31:0] s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   // pins
   logic        osc_1khz_in     = 1'b0;
   logic        ext_crystal_in  = 1'b0;
   logic        analog_comparator_out;
   logic        watchdog_clock_select;
   logic        watchdog_tick;
   logic        twowire_pin_select;
   logic        comparator_to_capture;
   logic        capture_ch0_from_comparator;
   logic        wakeup_request;
   logic        irq;
   // bench state
   int          fail_count      = 0;
   int          samples_checked = 0;
   int          cyc             = 0;
   logic [2:0]  phase           = 3'h0;
   int          int_ticks[7]    = '{8, 32, 64, 128, 256, 512, 1024};
   int          ext_ticks[3]    = '{256, 1024, 2048};

   sysopt_top #(.PART_NUMBER(PN)) i_dut (.*);

   // bus clock, 40 ns
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // cycle count; 1-kHz stand-in levels last four cycles, crystal two,
   // so a wrong source pick shows up as a wrong period
   always @(posedge aclk)
   begin
      cyc            <= cyc + 1;
      phase          <= phase + 3'h1;
      osc_1khz_in    <= phase[2];
      ext_crystal_in <= phase[1] ^ phase[0];
   end

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // synchronous reset held four cycles
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // one write, response compared
   task automatic wr(input logic [31:0] a, input logic [7:0] d,
                     input logic [3:0] st, input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_wstrb   <= st;
      s_axi_wvalid  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      // no answer within the limit counts as a mismatch
      if (s_axi_bvalid !== 1'b1)
         fail_count++;
      `CHECK(s_axi_bresp, er)
   endtask

   // one read, data and response compared
   task automatic rd(input logic [31:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      // no answer within the limit counts as a mismatch
      if (s_axi_rvalid !== 1'b1)
         fail_count++;
      `CHECK(s_axi_rdata, {24'h00_0000, ed})
      `CHECK(s_axi_rresp, er)
   endtask

   // watchdog ticks seen over forty cycles
   task automatic tick_count(input int e);
      int n;
      n = 0;
      repeat (40)
      begin
         @(posedge aclk);
         if (watchdog_tick === 1'b1)
            n++;
      end
      `CHECK(n, e)
   endtask

   // cycle of the next rise of the wakeup request
   task automatic wait_rise(output int t);
      logic prev;
      prev = wakeup_request;
      t = 0;
      repeat (40000)
      begin
         @(posedge aclk);
         if (wakeup_request === 1'b1 && prev === 1'b0)
         begin
            t = cyc;
            return;
         end
         prev = wakeup_request;
      end
      fail_count++;
   endtask

   // steady period and early first timeout, each acknowledged
   task automatic period_chk(input logic cs, input logic [2:0] code,
                             input int nom);
      int tc;
      int t0;
      int t1;
      wr(WK, {2'b00, cs, 1'b1, 1'b0, code}, 4'h1, OK);
      tc = cyc;
      wait_rise(t0);
      wr(WK, {2'b01, cs, 1'b1, 1'b0, code}, 4'h1, OK);
      wait_rise(t1);
      wr(WK, {2'b01, cs, 1'b1, 1'b0, code}, 4'h1, OK);
      `CHECK(t1 - t0, nom)
      `CHECK((t0 - tc >= nom - 8) && (t0 - tc <= nom + 12), 1'b1)
   endtask

   // hang guard, well beyond the roughly sixty thousand cycles needed
   initial
   begin
      repeat (80000) @(posedge aclk);
      fail_count++;
      close_out();
   end

   // main sequence
   initial
   begin
      aresetn               = 1'b0;
      s_axi_awaddr          = 32'h0000_0000;
      s_axi_awvalid         = 1'b0;
      s_axi_wdata           = 32'h0000_0000;
      s_axi_wstrb           = 4'h0;
      s_axi_wvalid          = 1'b0;
      // both answer channels held ready for the whole run
      s_axi_bready          = 1'b1;
      s_axi_araddr          = 32'h0000_0000;
      s_axi_arvalid         = 1'b0;
      s_axi_rready          = 1'b1;
      analog_comparator_out = 1'b0;
      do_reset();
      // reset state and identification
      rd(OPT, 8'h00, OK);
      rd(`OFF_PART_NUMBER_HIGH, {4'h0, PN[11:8]}, OK);
      rd(`OFF_PART_NUMBER_LOW, PN[7:0], OK);
      rd(WK, 8'h00, OK);
      `CHECK({twowire_pin_select, wakeup_request, irq}, 3'h0)
      wr(`OFF_PART_NUMBER_HIGH, 8'hFF, 4'h1, OK);
      wr(`OFF_PART_NUMBER_LOW, ~PN[7:0], 4'h1, OK);
      rd(`OFF_PART_NUMBER_HIGH, {4'h0, PN[11:8]}, OK);
      rd(`OFF_PART_NUMBER_LOW, PN[7:0], OK);
      wr(32'h0000_0018, 8'hFF, 4'h1, ERR);
      rd(32'h0000_0018, 8'h00, ERR);
      // watchdog select locked at bus clock by the first write
      wr(OPT, 8'h00, 4'h1, OK);
      wr(OPT, 8'h83, 4'h1, OK);
      rd(OPT, 8'h03, OK);
      analog_comparator_out <= 1'b1;
      repeat (6) @(posedge aclk);
      `CHECK(twowire_pin_select, 1'b1)
      `CHECK(capture_ch0_from_comparator, 1'b1)
      tick_count(40);
      wr(OPT, 8'h02, 4'h1, OK);
      wr(OPT, 8'h01, 4'hE, OK);
      repeat (6) @(posedge aclk);
      `CHECK({comparator_to_capture, capture_ch0_from_comparator}, 2'h0)
      rd(OPT, 8'h02, OK);
      // second reset reopens the one write
      do_reset();
      wr(OPT, 8'h80, 4'h1, OK);
      wr(OPT, 8'h01, 4'h1, OK);
      rd(OPT, 8'h81, OK);
      `CHECK(watchdog_clock_select, 1'b1)
      tick_count(5);
      analog_comparator_out <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHECK(capture_ch0_from_comparator, 1'b0)
      // flag with request blocked, then allowed, then acknowledged
      wr(WK, 8'h01, 4'h1, OK);
      repeat (100) @(posedge aclk);
      rd(WK, 8'h81, OK);
      `CHECK(wakeup_request, 1'b0)
      wr(WK, 8'h11, 4'h1, OK);
      repeat (3) @(posedge aclk);
      `CHECK(wakeup_request, 1'b1)
      wr(WK, 8'h10, 4'h1, OK);
      repeat (10) @(posedge aclk);
      rd(WK, 8'h90, OK);
      wr(WK, 8'h50, 4'h1, OK);
      repeat (3) @(posedge aclk);
      `CHECK(wakeup_request, 1'b0)
      repeat (300) @(posedge aclk);
      rd(WK, 8'h10, OK);
      // every internal period and the short external ones
      for (int i = 0; i < 7; i++)
         period_chk(1'b0, 3'(i + 1), int_ticks[i] * 8);
      for (int i = 0; i < 3; i++)
         period_chk(1'b1, 3'(i + 1), ext_ticks[i] * 4);
      // sticky event, mask and write-one clear
      wr(WK, 8'h00, 4'h1, OK);
      repeat (10) @(posedge aclk);
      rd(STA, 8'h01, OK);
      `CHECK(irq, 1'b0)
      wr(MSK, 8'h01, 4'h1, OK);
      wr(STA, 8'h00, 4'h1, OK);
      repeat (3) @(posedge aclk);
      `CHECK(irq, 1'b1)
      wr(STA, 8'h01, 4'h1, OK);
      repeat (3) @(posedge aclk);
      `CHECK(irq, 1'b0)
      rd(STA, 8'h00, OK);
      close_out();
   end
endmodule
